// file: hw/rps_sequencer.sv
// module: power-up reset sequencer with avalon-mm control and status registers
//
// Summary of operation
// - sample five straps one rtc cycle after release
// - wake raises indicator, 32 ms stable, then check
// - wake gpio line is active low after reset
// - good check: main supply on, indicator off
// - 350 ms standby, then pll and clocks on
// - 16 ms pll stabilisation before next step
// - bus reset low until bus master bit set
// - core runs cold reset as bus master before that bit is set
// - rtc reset clears state and registers, except the sampled strap value
// - no self refresh during rtc reset
// - outputs defined from reset, before oscillator starts
// - sdram supply low from rtc reset onward
// - sdram supply rises with main supply
// - sdram supply then stays high
// - low battery: indicator drops one rtc later
`default_nettype none
module rps_sequencer #(
  parameter int DEBOUNCE_TICKS = rps_pkg::DEBOUNCE_TICKS, // wake stability time, rtc cycles
  parameter int STANDBY_TICKS = rps_pkg::STANDBY_TICKS,   // standby time, rtc cycles
  parameter int PLL_TICKS = rps_pkg::PLL_TICKS            // pll settle time, rtc cycles
) (
  input wire logic clock,                                 // 20 MHz system clock
  input wire logic reset,                                 // async reset, high
  input wire logic rtc_domain_reset_n,                    // rtc-domain reset pin, low active
  input wire logic wake_button,                           // power button, high active
  input wire logic carrier_detect_wake_n,                 // carrier-detect wake, low active
  input wire logic wake_gpio_line,                        // gpio wake, level set by control
  input wire logic battery_inhibit_in,                    // battery ok when high
  input wire logic data_bus_width_strap,                  // strap
  input wire logic compact_isa_enable_strap,              // strap
  input wire logic clock_select_strap_2,                  // strap
  input wire logic clock_select_strap_1,                  // strap
  input wire logic clock_select_strap_0,                  // strap
  input wire logic [rps_pkg::ADDR_W-1:0] avs_address,     // byte address
  input wire logic avs_read,                              // read request
  input wire logic avs_write,                             // write request
  input wire logic [31:0] avs_writedata,                  // write data
  input wire logic [3:0] avs_byteenable,                  // byte lanes
  output logic [31:0] avs_readdata,                       // read data
  output logic avs_waitrequest,                           // stall
  output logic wake_indicator,                            // wake seen, supplies may be readied
  output logic main_supply_enable,                        // main supply on
  output logic sdram_supply_enable,                       // sdram supply on
  output logic pll_enable,                                // pll running
  output logic clocks_enable,                             // internal clocks running
  output logic bus_reset_n,                               // system bus reset, low active
  output logic cpu_cold_reset,                            // core held in cold reset
  output logic cpu_bus_master,                            // core owns the system bus
  output logic cold_reset_start,                          // one-cycle pulse at core release
  output logic [rps_pkg::STRAP_W-1:0] strap_value         // sampled straps
);
  // ----------------------------------------
  // pin filtering
  // ----------------------------------------
  rps_pin_if pins ();

  assign pins.raw = {clock_select_strap_0, clock_select_strap_1, clock_select_strap_2,
                     compact_isa_enable_strap, data_bus_width_strap, battery_inhibit_in,
                     wake_gpio_line, carrier_detect_wake_n, wake_button, rtc_domain_reset_n};

  rps_pin_sync u_sync (
    .clock(clock),
    .reset(reset),
    .pins(pins)
  );

  wire rtc_run = pins.clean[rps_pkg::PIN_RTC_RST];
  wire batt_ok = pins.clean[rps_pkg::PIN_BATT];

  // ----------------------------------------
  // rtc cycle enable
  // ----------------------------------------
  // phase accumulator gives an exact 32.768 kHz average rate from 20 MHz
  logic [rps_pkg::ACC_W-1:0] acc;
  logic rtc_tick;
  logic [rps_pkg::RTC_CNT_W-1:0] rtc_count;
  wire [rps_pkg::ACC_W-1:0] acc_sum = acc + rps_pkg::ACC_W'(rps_pkg::RTC_HZ);
  wire acc_wrap = acc_sum >= rps_pkg::ACC_W'(rps_pkg::CLK_HZ);
  wire [rps_pkg::ACC_W-1:0] next_acc = acc_wrap ? acc_sum - rps_pkg::ACC_W'(rps_pkg::CLK_HZ) : acc_sum;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc <= '0;
      rtc_tick <= 1'b0;
      rtc_count <= '0;
    end else if (!rtc_run) begin
      acc <= '0;
      rtc_tick <= 1'b0;
      rtc_count <= '0;
    end else begin
      acc <= next_acc;
      rtc_tick <= acc_wrap;
      rtc_count <= rtc_count + (acc_wrap ? 16'h0001 : 16'h0000);
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [rps_pkg::CTL_W-1:0] control;
  wire bus_master_enable_bit = control[rps_pkg::CTL_BUS_MASTER_ENABLE_BIT];
  wire gpio_high = control[rps_pkg::CTL_GPIO_POL];

  // ----------------------------------------
  // wake sources
  // ----------------------------------------
  // gpio is low active unless software flips the polarity bit
  wire gpio_active = pins.clean[rps_pkg::PIN_GPIO] ^ ~gpio_high;
  wire [2:0] wake_vec = {gpio_active, ~pins.clean[rps_pkg::PIN_DCD], pins.clean[rps_pkg::PIN_BUTTON]};
  wire wake_any = |wake_vec;
  logic wake_prev;
  logic [2:0] wake_seen;
  // only a fresh activation starts a sequence, so a held button after a refusal does not loop
  wire wake_rise = wake_any & ~wake_prev;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  rps_pkg::rps_state_t state;
  rps_pkg::rps_state_t next_state;
  logic [rps_pkg::CNT_W-1:0] cnt;
  logic batt_fail;

  wire deb_done = rtc_tick && cnt == rps_pkg::CNT_W'(DEBOUNCE_TICKS - 1);
  wire stby_done = rtc_tick && cnt == rps_pkg::CNT_W'(STANDBY_TICKS - 1);
  wire pll_done = rtc_tick && cnt == rps_pkg::CNT_W'(PLL_TICKS - 1);

  always_comb begin
    next_state = state;
    unique case (state)
      rps_pkg::S_RTC_HOLD: begin
        if (rtc_run) begin
          next_state = rps_pkg::S_STRAP;
        end
      end
      rps_pkg::S_STRAP: begin
        if (rtc_tick) begin
          next_state = rps_pkg::S_IDLE;
        end
      end
      rps_pkg::S_IDLE: begin
        if (wake_rise) begin
          next_state = rps_pkg::S_DEBOUNCE;
        end
      end
      rps_pkg::S_DEBOUNCE: begin
        if (wake_vec != wake_seen) begin
          next_state = rps_pkg::S_IDLE;
        end else if (deb_done) begin
          next_state = rps_pkg::S_BATT;
        end
      end
      rps_pkg::S_BATT: begin
        if (rtc_tick) begin
          next_state = batt_ok ? rps_pkg::S_STANDBY : rps_pkg::S_REFUSE;
        end
      end
      rps_pkg::S_REFUSE: begin
        if (rtc_tick) begin
          next_state = rps_pkg::S_IDLE;
        end
      end
      rps_pkg::S_STANDBY: begin
        if (stby_done) begin
          next_state = rps_pkg::S_PLL;
        end
      end
      rps_pkg::S_PLL: begin
        if (pll_done) begin
          next_state = rps_pkg::S_BUS_RESET;
        end
      end
      rps_pkg::S_BUS_RESET: begin
        if (bus_master_enable_bit) begin
          next_state = rps_pkg::S_RUN;
        end
      end
      rps_pkg::S_RUN: begin
        next_state = rps_pkg::S_RUN;
      end
    endcase
    // rtc reset overrides every state and forces rtc hold
    if (!rtc_run) begin
      next_state = rps_pkg::S_RTC_HOLD;
    end
  end

  wire change = next_state != state;
  wire next_wake = next_state inside {rps_pkg::S_DEBOUNCE, rps_pkg::S_BATT, rps_pkg::S_REFUSE};
  wire next_main = next_state inside {rps_pkg::S_STANDBY, rps_pkg::S_PLL, rps_pkg::S_BUS_RESET,
                                      rps_pkg::S_RUN};
  wire next_pll = next_state inside {rps_pkg::S_PLL, rps_pkg::S_BUS_RESET, rps_pkg::S_RUN};
  wire next_master = next_state inside {rps_pkg::S_BUS_RESET, rps_pkg::S_RUN};
  wire strap_load = state == rps_pkg::S_STRAP && rtc_tick;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= rps_pkg::S_RTC_HOLD;
      cnt <= '0;
      wake_prev <= 1'b1;
      wake_seen <= '0;
    end else begin
      state <= next_state;
      cnt <= change ? '0 : cnt + (rtc_tick ? 14'h0001 : 14'h0000);
      wake_prev <= wake_any;
      wake_seen <= (state == rps_pkg::S_IDLE) ? wake_vec : wake_seen;
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  // every output has a defined level from reset, ahead of the oscillator
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wake_indicator <= 1'b0;
      main_supply_enable <= 1'b0;
      pll_enable <= 1'b0;
      clocks_enable <= 1'b0;
      bus_reset_n <= 1'b0;
      cpu_cold_reset <= 1'b1;
      cpu_bus_master <= 1'b0;
      cold_reset_start <= 1'b0;
    end else begin
      wake_indicator <= next_wake;
      main_supply_enable <= next_main;
      pll_enable <= next_pll;
      clocks_enable <= next_pll;
      bus_reset_n <= next_state == rps_pkg::S_RUN;
      cpu_cold_reset <= !next_master;
      cpu_bus_master <= next_master;
      cold_reset_start <= change && next_state == rps_pkg::S_BUS_RESET;
    end
  end

  // no self-refresh request exists on this path: an rtc reset simply drops the dram supply
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sdram_supply_enable <= 1'b0;
    end else if (!rtc_run) begin
      sdram_supply_enable <= 1'b0;
    end else if (next_main) begin
      sdram_supply_enable <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strap_value <= '0;
      batt_fail <= 1'b0;
    end else begin
      if (strap_load) begin
        strap_value <= pins.clean[rps_pkg::PIN_STRAP +: rps_pkg::STRAP_W];
      end
      if (!rtc_run) begin
        batt_fail <= 1'b0;
      end else if (state == rps_pkg::S_BATT && rtc_tick) begin
        batt_fail <= !batt_ok;
      end
    end
  end

  // ----------------------------------------
  // avalon-mm slave
  // ----------------------------------------
  // one wait state: data is built in the first cycle, accepted in the second
  logic ack;
  wire req = avs_read | avs_write;
  wire sel_ctl = avs_address == rps_pkg::REG_CONTROL;
  wire sel_sts = avs_address == rps_pkg::REG_STATUS;
  wire sel_strap = avs_address == rps_pkg::REG_STRAPS;
  wire ctl_wr = avs_write && ack && sel_ctl && avs_byteenable[0];
  wire [31:0] sts_word = {rtc_count, 4'h0, state, 2'h0, batt_fail, bus_reset_n,
                          pll_enable, sdram_supply_enable, main_supply_enable, wake_indicator};
  wire [31:0] rd_mux = sel_ctl ? {30'h0, control} :
                       sel_sts ? sts_word :
                       sel_strap ? {27'h0, strap_value} : 32'h0;

  assign avs_waitrequest = req & ~ack;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ack <= req & ~ack;
      avs_readdata <= (avs_read && !ack) ? rd_mux : avs_readdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control <= rps_pkg::CTL_RESET;
    end else if (!rtc_run) begin
      control <= rps_pkg::CTL_RESET;
    end else if (ctl_wr) begin
      control <= avs_writedata[rps_pkg::CTL_W-1:0];
    end
  end
endmodule
`default_nettype wire

// file: hw/rps_pkg.sv
// package: constants, pin map, register map and states of the reset/power sequencer
`default_nettype none
package rps_pkg;
  // ----------------------------------------
  // clocks and times
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int RTC_HZ = 32768;
  localparam int ACC_W = 25;
  localparam longint T_DEBOUNCE_US = 32000;
  localparam longint T_STANDBY_US = 350000;
  localparam longint T_PLL_US = 16000;
  // least times round up to whole rtc cycles
  localparam int DEBOUNCE_TICKS = int'((T_DEBOUNCE_US * RTC_HZ + 64'd999999) / 64'd1000000);
  localparam int STANDBY_TICKS = int'((T_STANDBY_US * RTC_HZ + 64'd999999) / 64'd1000000);
  localparam int PLL_TICKS = int'((T_PLL_US * RTC_HZ + 64'd999999) / 64'd1000000);
  localparam int CNT_W = 14;
  localparam int RTC_CNT_W = 16;
  // ----------------------------------------
  // pin map of the synchroniser vector
  // ----------------------------------------
  localparam int PIN_W = 10;
  localparam int PIN_RTC_RST = 0;
  localparam int PIN_BUTTON = 1;
  localparam int PIN_DCD = 2;
  localparam int PIN_GPIO = 3;
  localparam int PIN_BATT = 4;
  localparam int PIN_STRAP = 5;
  localparam int STRAP_W = 5;
  localparam logic [PIN_W-1:0] PIN_RESET = 10'h00C;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STRAPS = 4'h8;
  localparam int CTL_BUS_MASTER_ENABLE_BIT = 0;
  localparam int CTL_GPIO_POL = 1;
  localparam int CTL_W = 2;
  localparam logic [CTL_W-1:0] CTL_RESET = 2'h0;
  localparam int ST_WAKE = 0;
  localparam int ST_MAIN = 1;
  localparam int ST_SDRAM = 2;
  localparam int ST_PLL_ON = 3;
  localparam int ST_BUS_RST_N = 4;
  localparam int ST_BATT_FAIL = 5;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_RTC_LSB = 16;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_RTC_HOLD,
    S_STRAP,
    S_IDLE,
    S_DEBOUNCE,
    S_BATT,
    S_REFUSE,
    S_STANDBY,
    S_PLL,
    S_BUS_RESET,
    S_RUN
  } rps_state_t;
endpackage
`default_nettype wire

// file: hw/rps_pin_if.sv
// interface: raw pin levels in, filtered levels out
`default_nettype none
interface rps_pin_if;
  logic [rps_pkg::PIN_W-1:0] raw;
  logic [rps_pkg::PIN_W-1:0] clean;
  modport filt (input raw, output clean);
  modport seq (output raw, input clean);
endinterface
`default_nettype wire

// file: hw/rps_pin_sync.sv
// module: three-flop synchroniser for every pin the sequencer reads
`default_nettype none
module rps_pin_sync (
  input wire logic clock,   // system clock
  input wire logic reset,   // async reset, high
  rps_pin_if.filt pins      // raw pins in, clean levels out
);
  // ----------------------------------------
  // per-pin stages
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < rps_pkg::PIN_W; i = i + 1) begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      logic held;
      // s1 feeds only s2; a change counts once s2 and s3 agree
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          s1 <= rps_pkg::PIN_RESET[i];
          s2 <= rps_pkg::PIN_RESET[i];
          s3 <= rps_pkg::PIN_RESET[i];
          held <= rps_pkg::PIN_RESET[i];
        end else begin
          s1 <= pins.raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            held <= s3;
          end
        end
      end
      assign pins.clean[i] = held;
    end
  endgenerate
endmodule
`default_nettype wire

// file: tb/rps_sequencer_properties.sv
// checker: timing relations between the sequencer outputs and their causes
`default_nettype none
module rps_sequencer_chk #(
  parameter int STANDBY_TICKS = 6, // standby, rtc cycles
  parameter int PLL_TICKS = 3      // pll settle, rtc cycles
) (
  input wire logic clock,                             // clock
  input wire logic reset,                             // async reset
  input wire logic rtc_domain_reset_n,                // rtc reset pin
  input wire logic [rps_pkg::ADDR_W-1:0] avs_address, // address
  input wire logic avs_read,                          // read
  input wire logic avs_write,                         // write
  input wire logic [31:0] avs_writedata,              // write data
  input wire logic [3:0] avs_byteenable,              // lanes
  input wire logic avs_waitrequest,                   // stall
  input wire logic wake_indicator,                    // wake seen
  input wire logic main_supply_enable,                // main supply
  input wire logic sdram_supply_enable,               // sdram supply
  input wire logic pll_enable,                        // pll on
  input wire logic clocks_enable,                     // clocks on
  input wire logic bus_reset_n,                       // bus reset
  input wire logic cpu_cold_reset,                    // core reset
  input wire logic cpu_bus_master,                    // core owns bus
  input wire logic cold_reset_start                   // release pulse
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  // bounds keep one tick of slack: tick spacing is 610 or 611 clocks
  logic [23:0] main_cnt;
  logic [23:0] pll_cnt;
  logic [3:0] rtc_hi;
  logic ctl_set;
  assign ctl_set = avs_write && !avs_waitrequest && avs_address == rps_pkg::REG_CONTROL
    && avs_byteenable[0] && avs_writedata[0];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      main_cnt <= 24'h0;
      pll_cnt <= 24'h0;
      rtc_hi <= 4'h0;
    end else begin
      main_cnt <= (main_supply_enable && !pll_enable) ? main_cnt + 24'h1 : 24'h0;
      pll_cnt <= (pll_enable && cpu_cold_reset) ? pll_cnt + 24'h1 : 24'h0;
      rtc_hi <= !rtc_domain_reset_n ? 4'h0 : (rtc_hi == 4'hF ? rtc_hi : rtc_hi + 4'h1);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_sdram_with_main: assert property ($rose(main_supply_enable) == $rose(sdram_supply_enable))
    else $error("sdram supply and main supply did not rise together");
  a_main_ind_off: assert property ($rose(main_supply_enable) |-> !wake_indicator && $past(wake_indicator))
    else $error("indicator not dropped as main supply rose");
  a_sdram_kept: assert property (sdram_supply_enable && rtc_hi == 4'hF |=> sdram_supply_enable)
    else $error("sdram supply dropped without rtc reset");
  a_rtc_clears: assert property (!rtc_domain_reset_n [*8] |-> !sdram_supply_enable && !main_supply_enable
    && cpu_cold_reset) else $error("rtc reset did not clear supplies");
  a_standby_time: assert property ($rose(pll_enable) |-> clocks_enable && main_supply_enable
    && main_cnt >= STANDBY_TICKS * 600 && main_cnt <= (STANDBY_TICKS + 1) * 620)
    else $error("pll started at wrong standby time");
  a_pll_settle: assert property ($fell(cpu_cold_reset) |-> pll_cnt >= PLL_TICKS * 600
    && pll_cnt <= (PLL_TICKS + 1) * 620) else $error("core released at wrong settle time");
  a_master_release: assert property ($fell(cpu_cold_reset) |-> cpu_bus_master && cold_reset_start)
    else $error("core release without bus master or pulse");
  a_pulse_single: assert property (cold_reset_start |=> !cold_reset_start)
    else $error("release pulse longer than one cycle");
  a_bus_rst_cause: assert property ($rose(bus_reset_n) |-> $past(ctl_set) || $past(ctl_set, 2))
    else $error("bus reset released without bus master bit");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  c_power_up: cover property ($rose(main_supply_enable));
  c_refused: cover property ($fell(wake_indicator) && !main_supply_enable);
  c_bus_free: cover property ($rose(bus_reset_n));
endmodule
bind rps_sequencer rps_sequencer_chk #(.STANDBY_TICKS(STANDBY_TICKS), .PLL_TICKS(PLL_TICKS)) chk (
  .clock, .reset, .rtc_domain_reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .wake_indicator, .main_supply_enable, .sdram_supply_enable,
  .pll_enable, .clocks_enable, .bus_reset_n, .cpu_cold_reset, .cpu_bus_master, .cold_reset_start);
`default_nettype wire

// file: tb/rps_far_side.sv
// partner model: rtc reset pin, wake sources, battery monitor and straps
`default_nettype none
module rps_far_side (
  input wire logic clock,            // clock
  output logic rtc_domain_reset_n,   // rtc reset pin
  output logic wake_button,          // power button
  output logic carrier_detect_wake_n, // carrier wake
  output logic wake_gpio_line,       // gpio wake
  output logic battery_inhibit_in,   // battery ok
  output logic [4:0] straps          // {sel0,sel1,sel2,isa,width}
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rtc_domain_reset_n = 1'h0;
    wake_button = 1'h0;
    carrier_detect_wake_n = 1'h1;
    wake_gpio_line = 1'h1;
    battery_inhibit_in = 1'h1;
    straps = 5'h0;
  end
  // ----------------------------------------
  // far-side actions
  // ----------------------------------------
  // oscillator start-up shortened to 40 clocks to keep the run short
  task power_up(input logic [4:0] s);
    @(posedge clock);
    rtc_domain_reset_n <= 1'h0;
    straps <= s;
    repeat (40) @(posedge clock);
    rtc_domain_reset_n <= 1'h1;
  endtask
  task wake(input logic [2:0] w);
    @(posedge clock);
    wake_button <= w[0];
    carrier_detect_wake_n <= !w[1];
    wake_gpio_line <= !w[2];
  endtask
  task batt(input logic b);
    @(posedge clock);
    battery_inhibit_in <= b;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_rps_sequencer.sv
// testbench: power-up sequencing of the reset and power sequencer
`default_nettype none
module tb_rps_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 620;
  logic clock, reset, rtc_domain_reset_n, wake_button, carrier_detect_wake_n, wake_gpio_line;
  logic battery_inhibit_in, avs_read, avs_write, avs_waitrequest, wake_indicator;
  logic main_supply_enable, sdram_supply_enable, pll_enable, clocks_enable, bus_reset_n;
  logic cpu_cold_reset, cpu_bus_master, cold_reset_start;
  logic [4:0] straps, strap_value;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  int error_cnt, n_checks;
  rps_sequencer #(.DEBOUNCE_TICKS(4), .STANDBY_TICKS(6), .PLL_TICKS(3)) dut (
    .clock, .reset, .rtc_domain_reset_n, .wake_button, .carrier_detect_wake_n, .wake_gpio_line,
    .battery_inhibit_in, .data_bus_width_strap(straps[0]), .compact_isa_enable_strap(straps[1]),
    .clock_select_strap_2(straps[2]), .clock_select_strap_1(straps[3]), .clock_select_strap_0(straps[4]),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .wake_indicator, .main_supply_enable, .sdram_supply_enable, .pll_enable,
    .clocks_enable, .bus_reset_n, .cpu_cold_reset, .cpu_bus_master, .cold_reset_start, .strap_value);
  rps_far_side far (.clock, .rtc_domain_reset_n, .wake_button, .carrier_detect_wake_n,
    .wake_gpio_line, .battery_inhibit_in, .straps);
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------
  // shared tasks and scenarios
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk(nm, v, s);
  endtask
  task automatic t_start(input logic [4:0] s);
    logic [31:0] q;
    far.power_up(s);
    chk("main", 1'h0, main_supply_enable);
    chk("sdram", 1'h0, sdram_supply_enable);
    chk("cold", 1'h1, cpu_cold_reset);
    bus(1'h0, rps_pkg::REG_CONTROL, 32'h0, q);
    chk("control", 32'h0, q);
    for (int i = 0; i < 2 * TK && strap_value !== s; i++) @(negedge clock);
    chk("straps", s, strap_value);
    bus(1'h0, rps_pkg::REG_STRAPS, 32'h0, q);
    chk("strap reg", s, q);
    bus(1'h0, 4'hC, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_refuse;
    logic [31:0] q;
    time t0;
    far.batt(1'h0);
    far.wake(3'h1);
    wait_on(wake_indicator, 1'h1, 20, "indicator up");
    t0 = $time;
    wait_on(wake_indicator, 1'h0, 8 * TK, "indicator down");
    chk("debounce", 1'h1, ($time - t0) >= 4 * 600 * 50);
    chk("main", 1'h0, main_supply_enable);
    bus(1'h0, rps_pkg::REG_STATUS, 32'h0, q);
    chk("batt fail", 1'h1, q[5]);
    far.wake(3'h0);
  endtask
  task automatic t_gpio_high;
    logic [31:0] q;
    repeat (8) @(posedge clock);
    // the gpio line rests high, so flipping the polarity bit alone raises a wake
    bus(1'h1, rps_pkg::REG_CONTROL, 32'h2, q);
    wait_on(wake_indicator, 1'h1, 20, "gpio high wake");
    far.wake(3'h4);
    wait_on(wake_indicator, 1'h0, 20, "debounce abort");
    far.wake(3'h0);
  endtask
  task automatic t_power(input logic [2:0] w);
    logic [31:0] q;
    far.batt(1'h1);
    far.wake(w);
    wait_on(main_supply_enable, 1'h1, 7 * TK, "main");
    chk("sdram", 1'h1, sdram_supply_enable);
    chk("indicator", 1'h0, wake_indicator);
    wait_on(pll_enable, 1'h1, 8 * TK, "pll");
    chk("clocks", 1'h1, clocks_enable);
    chk("cold", 1'h1, cpu_cold_reset);
    wait_on(cpu_bus_master, 1'h1, 5 * TK, "master");
    chk("bus reset", 1'h0, bus_reset_n);
    bus(1'h1, rps_pkg::REG_CONTROL, 32'h0, q);
    repeat (4) @(negedge clock);
    chk("bus reset held", 1'h0, bus_reset_n);
    @(posedge clock);
    avs_byteenable <= 4'hE;
    bus(1'h1, rps_pkg::REG_CONTROL, 32'h1, q);
    avs_byteenable <= 4'hF;
    bus(1'h0, rps_pkg::REG_CONTROL, 32'h0, q);
    chk("lane 0 off", 32'h0, q);
    bus(1'h1, rps_pkg::REG_CONTROL, 32'h1, q);
    wait_on(bus_reset_n, 1'h1, 4, "bus reset");
    far.wake(3'h0);
    chk("sdram kept", 1'h1, sdram_supply_enable);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end
  initial begin
    reset = 1'h1;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    error_cnt = 0;
    n_checks = 0;
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    t_start(5'h16);
    t_refuse();
    t_gpio_high();
    t_start(5'h09);
    t_power(3'h4);
    t_start(5'h16);
    t_power(3'h2);
    end_of_test();
  end
endmodule
`default_nettype wire
